// [design/uho_consts.svh]
// offsets, field positions, reset values and timing counts of the otg control block
`ifndef UHO_CONSTS_SVH
`define UHO_CONSTS_SVH
// ----------------------------------------
// register word addresses
// ----------------------------------------
`define UHO_A_ADDR    4'h0
`define UHO_A_TOK     4'h1
`define UHO_A_SOF     4'h2
`define UHO_A_CFG1    4'h3
`define UHO_A_CFG2    4'h4
`define UHO_A_OTGIR   4'h5
`define UHO_A_OTGIE   4'h6
`define UHO_A_DEVIR   4'h7
`define UHO_A_PWR     4'h8
`define UHO_A_LINE    4'h9
// ----------------------------------------
// field positions
// ----------------------------------------
`define UHO_B_SLOW    7
`define UHO_B_EYE     7
`define UHO_B_DRVMON  6
`define UHO_B_IDLE    4
`define UHO_B_CMPSEL  5
`define UHO_B_PULLUP  4
`define UHO_B_EXTSER  3
`define UHO_B_CMPOFF  1
`define UHO_B_PHYOFF  0
`define UHO_B_PWR     0
`define UHO_B_ID      7
`define UHO_B_MS      6
`define UHO_B_LINE    5
`define UHO_B_ACT     4
`define UHO_B_SESVD   3
`define UHO_B_SESEND  2
`define UHO_B_VBUSVD  0
// ----------------------------------------
// masks, codes, reset values
// ----------------------------------------
`define UHO_CFG1_MASK 8'hD3
`define UHO_CFG2_MASK 8'h3B
`define UHO_OTG_MASK  8'hFD
`define UHO_RST8      8'h00
`define UHO_PID_SETUP 4'hD
`define UHO_PID_IN    4'h9
`define UHO_PID_OUT   4'h1
`define UHO_PP_NONE   2'h0
`define UHO_PP_EP0OUT 2'h1
`define UHO_PP_ALL    2'h2
`define UHO_PP_EP1_15 2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define UHO_CLK_PS    4000
`define UHO_MS_PS     1000000000
`define UHO_MS_CYCLES (`UHO_MS_PS / `UHO_CLK_PS)
`endif

// [design/uho_ctrl.sv]
// otg host configuration registers, token issue and otg event flags
`timescale 1ns/1ps
`include "uho_consts.svh"

// How it works
// - slow select set runs host link low speed, clear runs full speed
// - address register keeps seven-bit function address, zero after reset
// - slow select reads zero and has no effect in device operation
// - token type 1101 setup, 1001 in, 0001 out starts a token
// - frame threshold is ten plus packet size; no token once passed
// - eye test bit drives the eye pattern sequence while set
// - drive monitor shows line driving, only with on-chip transceiver off
// - idle halt bit stops the block while processor is idle
// - select bit picks which pin set feeds external vbus status
// - id input change sets id change flag
// - one millisecond timer sets its flag at each expiry
// - line state stable one millisecond at new value sets flag
// - activity on data lines or vbus sets activity flag
// - vbus threshold crossings either way set their change flags
// - flags clear only by word write with one in position
// - each otg flag has an enable; request only for enabled set otg flag; device flags have no enable and no request
// - power bit gates the run enable, transceiver and comparator enables and otg event detection
// - j level flag follows speed-dependent differential j state
module uho_ctrl #(
	parameter int unsigned MS_CYCLES = `UHO_MS_CYCLES
) (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic [3:0]          reg_addr,
	input  wire logic [15:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [15:0]              reg_rdata,
	input  wire logic                host_mode,
	input  wire logic                cpu_idle,
	input  wire logic                int_dp,
	input  wire logic                int_dm,
	input  wire logic                ext_dp,
	input  wire logic                ext_dm,
	input  wire logic                line_drive,
	input  wire logic                id_in,
	input  wire logic [2:0]          cmp_in,
	input  wire logic [2:0]          ext_a_cmp,
	input  wire logic [2:0]          ext_b_cmp,
	input  wire logic [7:0]          frame_remaining,
	input  wire logic [7:0]          dev_event,
	output logic [6:0]               func_addr,
	output logic                     link_low_speed,
	output logic                     token_start,
	output uho_pkg::uho_token_t      token_kind,
	output logic [3:0]               token_ep,
	output logic                     frame_open,
	output logic                     eye_test_active,
	output logic                     drive_monitor,
	output logic                     module_run,
	output logic [15:0]              pp_out_mask,
	output logic [15:0]              pp_in_mask,
	output logic                     onchip_phy_en,
	output logic                     ext_phy_en,
	output logic                     onchip_cmp_en,
	output logic                     ext_cmp_sel_b,
	output logic                     vbus_pullup_enable,
	output logic                     ext_module_serial_ctrl,
	output logic                     otg_irq
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0]                addr_q;
	logic [7:0]                tok_q;
	logic [7:0]                sof_q;
	logic [7:0]                cfg1_q;
	logic [7:0]                cfg2_q;
	logic [7:0]                otgie_q;
	logic                      pwr_q;
	logic                      tok_pend_q;
	logic                      tok_start_q;
	uho_pkg::uho_token_t       kind_q;
	uho_pkg::uho_token_t       kind_d;
	logic [15:0]               rdata_q;
	logic [15:0]               rdata_d;
	logic [7:0]                otg_flags;
	logic [7:0]                dev_flags;
	logic [7:0]                otg_set;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire wr_addr  = reg_wr & (reg_addr == `UHO_A_ADDR);
	wire wr_tok   = reg_wr & (reg_addr == `UHO_A_TOK);
	wire wr_sof   = reg_wr & (reg_addr == `UHO_A_SOF);
	wire wr_cfg1  = reg_wr & (reg_addr == `UHO_A_CFG1);
	wire wr_cfg2  = reg_wr & (reg_addr == `UHO_A_CFG2);
	wire wr_otgir = reg_wr & (reg_addr == `UHO_A_OTGIR);
	wire wr_otgie = reg_wr & (reg_addr == `UHO_A_OTGIE);
	wire wr_devir = reg_wr & (reg_addr == `UHO_A_DEVIR);
	wire wr_pwr   = reg_wr & (reg_addr == `UHO_A_PWR);

	wire [7:0] cfg2_lock = pwr_q ? 8'h03 : 8'h00;
	wire [7:0] cfg2_wr   = ((reg_wdata[7:0] & ~cfg2_lock) | (cfg2_q & cfg2_lock))
		& `UHO_CFG2_MASK;

	wire [3:0] pid_w = reg_wdata[7:4];
	always_comb begin
		case (pid_w)
			`UHO_PID_SETUP: kind_d = uho_pkg::UHO_TOK_SETUP;
			`UHO_PID_IN:    kind_d = uho_pkg::UHO_TOK_IN;
			`UHO_PID_OUT:   kind_d = uho_pkg::UHO_TOK_OUT;
			default:        kind_d = uho_pkg::UHO_TOK_NONE;
		endcase
	end
	wire tok_valid = (kind_d != uho_pkg::UHO_TOK_NONE);

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q  <= `UHO_RST8;
			tok_q   <= `UHO_RST8;
			sof_q   <= `UHO_RST8;
			cfg1_q  <= `UHO_RST8;
			cfg2_q  <= `UHO_RST8;
			otgie_q <= `UHO_RST8;
			pwr_q   <= 1'b0;
		end else begin
			if (wr_addr) addr_q <= reg_wdata[7:0];
			if (wr_tok) tok_q <= reg_wdata[7:0];
			if (wr_sof) sof_q <= reg_wdata[7:0];
			if (wr_cfg1) cfg1_q <= reg_wdata[7:0] & `UHO_CFG1_MASK;
			if (wr_cfg2) cfg2_q <= cfg2_wr;
			if (wr_otgie) otgie_q <= reg_wdata[7:0] & `UHO_OTG_MASK;
			if (wr_pwr) pwr_q <= reg_wdata[`UHO_B_PWR];
		end
	end

	// ----------------------------------------
	// run control
	// ----------------------------------------
	// power gate
	assign module_run = pwr_q & ~(cfg1_q[`UHO_B_IDLE] & cpu_idle);

	assign link_low_speed = host_mode & addr_q[`UHO_B_SLOW];
	assign func_addr      = addr_q[6:0];

	assign frame_open = frame_remaining > sof_q;

	// ----------------------------------------
	// token issue
	// ----------------------------------------
	// pending token waits for window
	wire tok_fire = tok_pend_q & frame_open & module_run & host_mode & ~tok_start_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tok_pend_q  <= 1'b0;
			tok_start_q <= 1'b0;
			kind_q      <= uho_pkg::UHO_TOK_NONE;
		end else begin
			tok_start_q <= tok_fire;
			if (wr_tok) begin
				tok_pend_q <= tok_valid;
				kind_q     <= kind_d;
			end else if (tok_fire) begin
				tok_pend_q <= 1'b0;
			end
		end
	end
	assign token_start = tok_start_q;
	assign token_kind  = kind_q;
	assign token_ep    = tok_q[3:0];

	// ----------------------------------------
	// line and transceiver routing
	// ----------------------------------------
	// external transceiver path
	wire phy_off = cfg2_q[`UHO_B_PHYOFF];
	wire rx_dp   = phy_off ? ext_dp : int_dp;
	wire rx_dm   = phy_off ? ext_dm : int_dm;
	assign onchip_phy_en = pwr_q & ~phy_off;
	assign ext_phy_en    = pwr_q & phy_off;

	wire se0_now = ~rx_dp & ~rx_dm;
	wire j_now   = link_low_speed ? (rx_dm & ~rx_dp) : (rx_dp & ~rx_dm);
	wire [1:0] line_now = {se0_now, j_now};

	assign eye_test_active = cfg1_q[`UHO_B_EYE] & module_run;
	assign drive_monitor = cfg1_q[`UHO_B_DRVMON] & phy_off & line_drive & module_run;

	wire cmp_off = cfg2_q[`UHO_B_CMPOFF];
	assign ext_cmp_sel_b = cfg2_q[`UHO_B_CMPSEL];
	wire [2:0] vbus_now = cmp_off ? (ext_cmp_sel_b ? ext_b_cmp : ext_a_cmp) : cmp_in;
	assign onchip_cmp_en          = pwr_q & ~cmp_off;
	assign vbus_pullup_enable     = cfg2_q[`UHO_B_PULLUP];
	assign ext_module_serial_ctrl = cfg2_q[`UHO_B_EXTSER];

	wire [1:0] pp_mode = cfg1_q[1:0];
	always_comb begin
		case (pp_mode)
			`UHO_PP_NONE: begin
				pp_out_mask = 16'h0000;
				pp_in_mask  = 16'h0000;
			end
			`UHO_PP_EP0OUT: begin
				pp_out_mask = 16'h0001;
				pp_in_mask  = 16'h0000;
			end
			`UHO_PP_ALL: begin
				pp_out_mask = 16'hFFFF;
				pp_in_mask  = 16'hFFFF;
			end
			default: begin
				pp_out_mask = 16'hFFFE;
				pp_in_mask  = 16'hFFFE;
			end
		endcase
	end

	// ----------------------------------------
	// event detection
	// ----------------------------------------
	logic        id_q;
	logic [2:0]  vbus_q;
	logic [1:0]  lines_q;
	logic [1:0]  stable_q;
	logic [17:0] ms_cnt_q;
	logic [17:0] ls_cnt_q;
	logic        ms_tick;
	logic        ls_done;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			id_q    <= 1'b0;
			vbus_q  <= 3'h0;
			lines_q <= 2'h0;
		end else begin
			id_q    <= id_in;
			vbus_q  <= vbus_now;
			lines_q <= {rx_dp, rx_dm};
		end
	end

	assign ms_tick = module_run & (ms_cnt_q == 18'(MS_CYCLES - 1));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_q <= 18'h00000;
		end else if (!module_run || ms_tick) begin
			ms_cnt_q <= 18'h00000;
		end else begin
			ms_cnt_q <= ms_cnt_q + 18'h00001;
		end
	end

	logic [1:0] line_q;
	assign ls_done = module_run & (ls_cnt_q == 18'(MS_CYCLES - 1)) & (line_q != stable_q);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q   <= 2'h0;
			stable_q <= 2'h0;
			ls_cnt_q <= 18'h00000;
		end else begin
			line_q <= line_now;
			if (!module_run || line_now != line_q) begin
				ls_cnt_q <= 18'h00000;
			end else if (ls_cnt_q != 18'(MS_CYCLES - 1)) begin
				ls_cnt_q <= ls_cnt_q + 18'h00001;
			end
			if (ls_done) stable_q <= line_q;
		end
	end

	wire [2:0] vbus_x = vbus_now ^ vbus_q;
	always_comb begin
		otg_set               = 8'h00;
		otg_set[`UHO_B_ID]    = pwr_q & (id_in ^ id_q);
		otg_set[`UHO_B_MS]    = ms_tick;
		otg_set[`UHO_B_LINE]  = ls_done;
		otg_set[`UHO_B_ACT]   = pwr_q & ((|({rx_dp, rx_dm} ^ lines_q)) | (|vbus_x));
		otg_set[`UHO_B_SESVD] = pwr_q & vbus_x[2];
		otg_set[`UHO_B_SESEND] = pwr_q & vbus_x[1];
		otg_set[`UHO_B_VBUSVD] = pwr_q & vbus_x[0];
	end

	// ----------------------------------------
	// event flags
	// ----------------------------------------
	// word write clear
	wire [7:0] otg_set_m = otg_set & `UHO_OTG_MASK;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
			uho_flag u_otg (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.set      (otg_set_m[gi]),
				.clr      (wr_otgir & reg_wdata[gi]),
				.q        (otg_flags[gi])
			);
			uho_flag u_dev (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.set      (dev_event[gi]),
				.clr      (wr_devir & reg_wdata[gi]),
				.q        (dev_flags[gi])
			);
		end
	endgenerate

	assign otg_irq = |(otg_flags & otgie_q);

	// ----------------------------------------
	// read path
	// ----------------------------------------
	wire [7:0] addr_rd = host_mode ? addr_q : {1'b0, addr_q[6:0]};
	wire [7:0] line_rd = {j_now, se0_now, 1'b0, id_in, 1'b0, vbus_now};
	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`UHO_A_ADDR:  rdata_d = {8'h00, addr_rd};
				`UHO_A_TOK:   rdata_d = {8'h00, tok_q};
				`UHO_A_SOF:   rdata_d = {8'h00, sof_q};
				`UHO_A_CFG1:  rdata_d = {8'h00, cfg1_q};
				`UHO_A_CFG2:  rdata_d = {8'h00, cfg2_q};
				`UHO_A_OTGIR: rdata_d = {8'h00, otg_flags};
				`UHO_A_OTGIE: rdata_d = {8'h00, otgie_q};
				`UHO_A_DEVIR: rdata_d = {8'h00, dev_flags};
				`UHO_A_PWR:   rdata_d = {15'h0000, pwr_q};
				`UHO_A_LINE:  rdata_d = {8'h00, line_rd};
				default:      rdata_d = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	slow_dev_zero_a: assert property (
		reg_rd && reg_addr == `UHO_A_ADDR && !host_mode |=> !reg_rdata[7])
		else $error("slow select visible in device mode");
	addr_store_a: assert property (
		wr_addr ##1 reg_rd && reg_addr == `UHO_A_ADDR && !wr_addr |=>
		reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
		else $error("address not kept");
	token_issue_a: assert property (
		token_start |-> token_kind != uho_pkg::UHO_TOK_NONE && $past(frame_open))
		else $error("token started without valid type or window");
	frame_block_a: assert property (
		!frame_open throughout (##1 !frame_open) |-> !token_start)
		else $error("token started past threshold");
	drvmon_gate_a: assert property (
		drive_monitor |-> phy_off && line_drive)
		else $error("drive monitor with on-chip transceiver");
	idle_halt_a: assert property (
		cfg1_q[`UHO_B_IDLE] && cpu_idle |-> !module_run && !eye_test_active)
		else $error("block runs in idle");
	lock_keep_a: assert property (
		pwr_q && wr_cfg2 |=> cfg2_q[1:0] == $past(cfg2_q[1:0]))
		else $error("transceiver bits changed while powered");
	id_flag_a: assert property (
		pwr_q && (id_in != id_q) |=> otg_flags[`UHO_B_ID])
		else $error("id change missed");
	set_wins_a: assert property (
		otg_set[`UHO_B_ACT] && wr_otgir && reg_wdata[`UHO_B_ACT] |=> otg_flags[`UHO_B_ACT])
		else $error("clear beat hardware set");
	irq_gate_a: assert property (
		wr_otgie && |(reg_wdata[7:0] & otg_flags & `UHO_OTG_MASK) |=> otg_irq)
		else $error("enabled set flag gave no request");

	tok_c: cover property (wr_tok && tok_valid ##[1:20] token_start);
	line_c: cover property (otg_flags[`UHO_B_LINE]);
	clr_c: cover property (wr_otgir && |otg_flags ##1 !(|otg_flags));
	irq_c: cover property (otg_irq);
endmodule

// [design/uho_flag.sv]
// one sticky event flag, hardware set wins over write-one-to-clear
`timescale 1ns/1ps
module uho_flag (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	logic flag_q;
	logic flag_d;

	assign flag_d = set | (flag_q & ~clr);
	assign q      = flag_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
endmodule

// [design/uho_pkg.sv]
// types of the otg control block
package uho_pkg;
	typedef enum logic [1:0] {
		UHO_TOK_NONE,
		UHO_TOK_SETUP,
		UHO_TOK_IN,
		UHO_TOK_OUT
	} uho_token_t;
endpackage

// [testbench/test_usb_otg_host_config_and_otg_irq.sv]
// self-checking bench of the otg control block
`timescale 1ns/1ps
module test_usb_otg_host_config_and_otg_irq;
	localparam int MS = 50;
	logic                core_clk, rst_n, reg_wr, reg_rd, host_mode, cpu_idle, line_drive;
	logic                id_set, id_in, int_dp, int_dm, ext_dp, ext_dm, link_low_speed;
	logic                token_start, frame_open, eye_test_active, drive_monitor, module_run;
	logic                onchip_phy_en, ext_phy_en, onchip_cmp_en, ext_cmp_sel_b, otg_irq;
	logic                vbus_pullup_enable, ext_module_serial_ctrl;
	logic [1:0]          line_set;
	logic [2:0]          vbus_set, cmp_in, ext_a_cmp, ext_b_cmp, vs;
	logic [3:0]          reg_addr, token_ep, ep;
	logic [6:0]          func_addr;
	logic [7:0]          frame_remaining, dev_event;
	logic [15:0]         reg_wdata, reg_rdata, pp_out_mask, pp_in_mask, rv, d, last0;
	uho_pkg::uho_token_t token_kind;
	int                  mismatches = 0;
	int                  cmp_count = 0;
	int                  n;
	logic [3:0]          rw_addr [5] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6};
	logic [15:0]         rw_mask [5] = '{16'h00FF, 16'h00FF, 16'h00D3, 16'h003B, 16'h00FD};
	logic [3:0]          codes [3] = '{4'hD, 4'h9, 4'h1};

	uho_cable_model cable (.core_clk(core_clk), .id_set(id_set), .vbus_set(vbus_set),
		.line_set(line_set), .id_in(id_in), .cmp_in(cmp_in), .ext_a_cmp(ext_a_cmp),
		.ext_b_cmp(ext_b_cmp), .int_dp(int_dp), .int_dm(int_dm), .ext_dp(ext_dp),
		.ext_dm(ext_dm));

	uho_ctrl #(.MS_CYCLES(MS)) uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.host_mode(host_mode), .cpu_idle(cpu_idle), .int_dp(int_dp), .int_dm(int_dm),
		.ext_dp(ext_dp), .ext_dm(ext_dm), .line_drive(line_drive), .id_in(id_in),
		.cmp_in(cmp_in), .ext_a_cmp(ext_a_cmp), .ext_b_cmp(ext_b_cmp),
		.frame_remaining(frame_remaining), .dev_event(dev_event), .func_addr(func_addr),
		.link_low_speed(link_low_speed), .token_start(token_start), .token_kind(token_kind),
		.token_ep(token_ep), .frame_open(frame_open), .eye_test_active(eye_test_active),
		.drive_monitor(drive_monitor), .module_run(module_run), .pp_out_mask(pp_out_mask),
		.pp_in_mask(pp_in_mask), .onchip_phy_en(onchip_phy_en), .ext_phy_en(ext_phy_en),
		.onchip_cmp_en(onchip_cmp_en), .ext_cmp_sel_b(ext_cmp_sel_b),
		.vbus_pullup_enable(vbus_pullup_enable),
		.ext_module_serial_ctrl(ext_module_serial_ctrl), .otg_irq(otg_irq));

	// ----------------------------------------
	// expectations, compare and bus tasks
	// ----------------------------------------
	function automatic logic [31:0] pp_exp(input logic [1:0] m);
		case (m)
			2'h0: return 32'h0000_0000;
			2'h1: return 32'h0000_0001;
			2'h2: return 32'hFFFF_FFFF;
			default: return 32'hFFFE_FFFE;
		endcase
	endfunction
	function automatic uho_pkg::uho_token_t kind_exp(input logic [3:0] c);
		if (c == 4'hD) return uho_pkg::UHO_TOK_SETUP;
		if (c == 4'h9) return uho_pkg::UHO_TOK_IN;
		return uho_pkg::UHO_TOK_OUT;
	endfunction
	function automatic logic [15:0] vbus_flag(input int b);
		return (b == 2) ? 16'h0008 : ((b == 1) ? 16'h0004 : 16'h0001);
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		check(what, 32'(rv & m), 32'(e));
	endtask
	task automatic count_tok;
		n = 0;
		repeat (6) begin
			@(posedge core_clk);
			#1 if (token_start === 1'b1) n++;
		end
	endtask
	task automatic wait_cycles(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, host_mode, cpu_idle, line_drive, id_set} = 7'h00;
		{reg_addr, reg_wdata, frame_remaining, dev_event} = 36'h0;
		{vbus_set, line_set, vs} = 8'h00;
		rv = $urandom(32'h659B);
		wait_cycles(5);
		rst_n <= 1'b1;
		for (int a = 0; a < 9; a++) rdchk("reset value", 4'(a), 16'hFFFF, 16'h0000);
		rdchk("unmapped read", 4'hF, 16'hFFFF, 16'h0000);
		$display("test reset done");
		host_mode <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			for (int k = 0; k < 5; k++) begin
				d = (i == 0) ? 16'hFFFF : 16'($urandom);
				if (k == 0) last0 = d;
				wr(rw_addr[k], d);
				rdchk("register readback", rw_addr[k], 16'hFFFF, d & rw_mask[k]);
			end
		end
		check("function address", 32'(func_addr), 32'(last0[6:0]));
		check("low speed host", 32'(link_low_speed), 32'(last0[7]));
		host_mode <= 1'b0;
		wr(4'h0, 16'h0080);
		rdchk("slow bit device", 4'h0, 16'h0080, 16'h0000);
		check("low speed device", 32'(link_low_speed), 32'h0);
		$display("test registers done");
		wr(4'h4, 16'h0021);
		wr(4'h8, 16'h0001);
		line_drive <= 1'b1;
		wr(4'h3, 16'h00C0);
		#1 check("module run", 32'(module_run), 32'h1);
		check("eye test", 32'(eye_test_active), 32'h1);
		check("drive monitor", 32'(drive_monitor), 32'h1);
		check("phy routing", {onchip_phy_en, ext_phy_en}, 32'h1);
		check("comparator select", 32'(ext_cmp_sel_b), 32'h1);
		wr(4'h4, 16'h0010);
		rdchk("interlock", 4'h4, 16'hFFFF, 16'h0011);
		check("cfg2 outputs", {onchip_cmp_en, vbus_pullup_enable, ext_module_serial_ctrl}, 32'h6);
		cpu_idle <= 1'b1;
		wr(4'h3, 16'h00D0);
		#1 check("idle halt", {module_run, eye_test_active}, 32'h0);
		@(posedge core_clk);
		cpu_idle <= 1'b0;
		#1 check("idle run", 32'(module_run), 32'h1);
		wr(4'h8, 16'h0000);
		wr(4'h4, 16'h0000);
		wr(4'h8, 16'h0001);
		#1 check("monitor phy on", 32'(drive_monitor), 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(4'h3, 16'(m));
			#1 check("double buffer", {pp_in_mask, pp_out_mask}, pp_exp(2'(m)));
		end
		$display("test config done");
		host_mode <= 1'b1;
		frame_remaining <= 8'h4A;
		wr(4'h2, 16'h004A);
		#1 check("frame closed", 32'(frame_open), 32'h0);
		wr(4'h1, 16'h00D3);
		count_tok();
		check("token held", n, 32'h0);
		@(posedge core_clk);
		frame_remaining <= 8'h4B;
		count_tok();
		check("token released", {n[15:0], 12'h0, token_ep}, 32'h0001_0003);
		for (int j = 0; j < 3; j++) begin
			ep = 4'($urandom);
			wr(4'h1, {8'h00, codes[j], ep});
			count_tok();
			check("token count", n, 32'h1);
			check("token kind", {token_kind, token_ep}, {kind_exp(codes[j]), ep});
		end
		wr(4'h1, 16'h0053);
		count_tok();
		check("reserved token", n, 32'h0);
		$display("test tokens done");
		wr(4'h6, 16'h0000);
		wr(4'h5, 16'h00FF);
		id_set <= 1'b1;
		wait_cycles(3);
		rdchk("id change", 4'h5, 16'h0080, 16'h0080);
		check("irq masked", 32'(otg_irq), 32'h0);
		wr(4'h6, 16'h0080);
		#1 check("irq enabled", 32'(otg_irq), 32'h1);
		wr(4'h5, 16'h0080);
		rdchk("id clear", 4'h5, 16'h0080, 16'h0000);
		check("irq cleared", 32'(otg_irq), 32'h0);
		for (int b = 0; b < 6; b++) begin
			vs = vs ^ (3'b001 << (b % 3));
			wr(4'h5, 16'h00FF);
			vbus_set <= vs;
			wait_cycles(3);
			rdchk("vbus crossing", 4'h5, 16'h001D, vbus_flag(b % 3) | 16'h0010);
			wr(4'h5, vbus_flag(b % 3));
			rdchk("single clear", 4'h5, 16'h001D, 16'h0010);
		end
		wr(4'h5, 16'h00FF);
		line_set <= 2'b01;
		wait_cycles(3);
		rdchk("line activity", 4'h5, 16'h0010, 16'h0010);
		@(posedge core_clk);
		dev_event <= 8'hA5;
		@(posedge core_clk);
		dev_event <= 8'h00;
		rdchk("device flags", 4'h7, 16'hFFFF, 16'h00A5);
		wr(4'h7, 16'h0005);
		rdchk("device clear", 4'h7, 16'hFFFF, 16'h00A0);
		$display("test events done");
		wr(4'h0, 16'h0080);
		rdchk("j low speed", 4'h9, 16'h0080, 16'h0080);
		wr(4'h0, 16'h0000);
		rdchk("j full speed", 4'h9, 16'h0080, 16'h0000);
		line_set <= 2'b10;
		wr(4'h5, 16'h00FF);
		wait_cycles(MS + 10);
		rdchk("line stable", 4'h5, 16'h0020, 16'h0020);
		wr(4'h5, 16'h00FF);
		wait_cycles(MS + 10);
		rdchk("ms timer", 4'h5, 16'h0040, 16'h0040);
		rdchk("line unchanged", 4'h5, 16'h0020, 16'h0000);
		$display("test timers done");
		wr(4'h8, 16'h0000);
		wr(4'h4, 16'h0022);
		wr(4'h8, 16'h0001);
		rdchk("pin set b", 4'h9, 16'h0007, {13'h0, ~vs});
		check("comparator off", 32'(onchip_cmp_en), 32'h0);
		wr(4'h4, 16'h0002);
		rdchk("pin set a", 4'h9, 16'h0007, {13'h0, vs});
		$display("test comparators done");
		complete_run();
	end
endmodule

// [testbench/uho_cable_model.sv]
// cable partner model: id pin, vbus comparator levels and receive line levels
`timescale 1ns/1ps
module uho_cable_model (
	input  wire logic       core_clk,
	input  wire logic       id_set,
	input  wire logic [2:0] vbus_set,
	input  wire logic [1:0] line_set,
	output logic            id_in,
	output logic [2:0]      cmp_in,
	output logic [2:0]      ext_a_cmp,
	output logic [2:0]      ext_b_cmp,
	output logic            int_dp,
	output logic            int_dm,
	output logic            ext_dp,
	output logic            ext_dm
);
	initial begin
		{id_in, cmp_in, ext_a_cmp, ext_b_cmp} = 10'h000;
		{int_dp, int_dm, ext_dp, ext_dm} = 4'h0;
	end
	// levels settle one edge after a cable event; pin set b carries inverted levels
	always @(posedge core_clk) begin
		id_in <= id_set;
		cmp_in <= vbus_set;
		ext_a_cmp <= vbus_set;
		ext_b_cmp <= ~vbus_set;
		{int_dp, int_dm} <= line_set;
		{ext_dp, ext_dm} <= line_set;
	end
endmodule
